// ==== i2c_front_cfg.svh ====
/*
 Constants of the serial slave address front end: reset values, strap codes,
 address layout and the spike filter timing.
 Assumes inclusion by its bare name from the package and the design modules.
*/
// Operation
// - after stop, interface rests in standby
// - power-on reset clears bus logic, ports high
// - three straps select one of 64 addresses
// - last address bit one reads, zero writes
// - pulses under 50 ns never become edges
// - write: byte after address is command byte
`ifndef I2C_FRONT_CFG_SVH
`define I2C_FRONT_CFG_SVH

`define I2CF_CLK_PERIOD_NS 100
`define I2CF_SPIKE_NS 50
`define I2CF_FILT_CYCLES (((`I2CF_SPIKE_NS + `I2CF_CLK_PERIOD_NS - 1) / `I2CF_CLK_PERIOD_NS) < 1 ? \
   1 : ((`I2CF_SPIKE_NS + `I2CF_CLK_PERIOD_NS - 1) / `I2CF_CLK_PERIOD_NS))

`define I2CF_PORT_WIDTH 16
`define I2CF_PORT_RESET 16'hFFFF
`define I2CF_BYTE_BITS 4'h8
`define I2CF_CMD_RESET 8'h00
`define I2CF_DIR_BIT 0
`define I2CF_DIR_READ 1'b1

`define I2CF_STRAP_GND 2'h0
`define I2CF_STRAP_VDD 2'h1
`define I2CF_STRAP_SCL 2'h2
`define I2CF_STRAP_SDA 2'h3
`define I2CF_STRAP_BUS_BIT 1
`define I2CF_STRAP_HI_BIT 0

`endif

// ==== i2c_front_pkg.sv ====
/*
 Types of the serial slave address front end.
 Assumes i2c_front_cfg.svh on the include path.
*/
`include "i2c_front_cfg.svh"

package i2c_front_pkg;
   // strap pin tie: gnd, vdd, clock line or data line
   typedef logic [1:0] strap_t;
   typedef logic [6:0] addr7_t;
   typedef enum logic [2:0] {
      ST_STANDBY,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_CMD,
      ST_CMD_ACK,
      ST_BUSY,
      ST_IGNORE
   } state_e;
endpackage

// ==== glitch_filter.sv ====
/*
 Two-flop synchroniser followed by a spike filter for one bus line.
 Assumes an asynchronous pin input; output is a clean level on sys_clk.
*/
`timescale 1ns/1ps
`include "i2c_front_cfg.svh"

module glitch_filter #(
   parameter int FILT_CYCLES = `I2CF_FILT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic pin,
   output logic level_q
);
   localparam int CW = $clog2(FILT_CYCLES + 1) + 1;

   logic s1_q;
   logic s2_q;
   logic [CW-1:0] cnt_q;
   wire differ = (s2_q != level_q);
   wire accept = differ && (cnt_q == CW'(FILT_CYCLES));

   if (FILT_CYCLES < 1) begin : g_bad_filt
      $error("glitch_filter needs at least one filter cycle");
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         cnt_q <= '0;
         level_q <= 1'b1;
      end else if (ce) begin
         s1_q <= pin;
         s2_q <= s1_q;
         // a change must persist past the spike window before it counts
         cnt_q <= (differ && !accept) ? cnt_q + CW'(1) : '0;
         if (accept) begin
            level_q <= s2_q;
         end
      end
   end

   filter_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $changed(level_q) |-> $past(s2_q, 1) == level_q && $past(s2_q, 2) == level_q)
      else $error("filtered level changed on a short pulse");
endmodule

// ==== i2c_slave_address_front_end.sv ====
/*
 Serial slave front end: filters clock and data, detects start and stop,
 receives the address byte, acknowledges on match, takes the command byte
 of a write, and rests in standby between transfers.
 Assumes scl and sda arrive from pins; straps are 2-bit tie codes.
*/
`timescale 1ns/1ps
`include "i2c_front_cfg.svh"

module i2c_slave_address_front_end #(
   parameter int FILT_CYCLES = `I2CF_FILT_CYCLES,
   parameter int PORT_WIDTH = `I2CF_PORT_WIDTH
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out_q,
   output logic sda_oe_q,
   input wire i2c_front_pkg::strap_t addr_strap_bit0,
   input wire i2c_front_pkg::strap_t addr_strap_bit1,
   input wire i2c_front_pkg::strap_t addr_strap_bit2,
   output logic standby_q,
   output logic addr_match_q,
   output logic read_q,
   output logic cmd_valid_q,
   output logic [7:0] cmd_q,
   output logic [PORT_WIDTH-1:0] port_level_q
);
   import i2c_front_pkg::*;

   if (PORT_WIDTH != `I2CF_PORT_WIDTH) begin : g_width_check
      $error("port width must be 16");
   end

   // decode of the three strap ties into the slave address
   function automatic addr7_t strap_decode(strap_t s2, strap_t s1, strap_t s0);
      logic [3:0] top;
      top = 4'h0;
      case ({s2[`I2CF_STRAP_BUS_BIT], s1[`I2CF_STRAP_BUS_BIT]})
         2'b00: top = {3'b010, s0[`I2CF_STRAP_BUS_BIT]};
         2'b01: top = {3'b001, s0[`I2CF_STRAP_BUS_BIT]};
         2'b11: top = {3'b101, s0[`I2CF_STRAP_BUS_BIT]};
         default: top = {2'b11, s0[`I2CF_STRAP_BUS_BIT], 1'b0};
      endcase
      return {top, s2[`I2CF_STRAP_HI_BIT], s1[`I2CF_STRAP_HI_BIT], s0[`I2CF_STRAP_HI_BIT]};
   endfunction

   // bus lines: synchronise and strip spikes
   logic [1:0] line_raw;
   logic [1:0] line_f;
   assign line_raw = {sda_in, scl_in};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_line
         glitch_filter #(
            .FILT_CYCLES(FILT_CYCLES)
         ) u_filt (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .ce(ce),
            .pin(line_raw[gi]),
            .level_q(line_f[gi])
         );
      end
   endgenerate

   // straps are pins too: two flops before use
   strap_t st0_s1_q, st1_s1_q, st2_s1_q;
   strap_t st0_q, st1_q, st2_q;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st0_s1_q <= `I2CF_STRAP_GND;
         st1_s1_q <= `I2CF_STRAP_GND;
         st2_s1_q <= `I2CF_STRAP_GND;
         st0_q <= `I2CF_STRAP_GND;
         st1_q <= `I2CF_STRAP_GND;
         st2_q <= `I2CF_STRAP_GND;
      end else if (ce) begin
         st0_s1_q <= addr_strap_bit0;
         st1_s1_q <= addr_strap_bit1;
         st2_s1_q <= addr_strap_bit2;
         st0_q <= st0_s1_q;
         st1_q <= st1_s1_q;
         st2_q <= st2_s1_q;
      end
   end

   wire addr7_t own_addr = strap_decode(st2_q, st1_q, st0_q);

   // bus condition and edge detection on filtered lines
   logic scl_p_q;
   logic sda_p_q;
   wire scl_f = line_f[0];
   wire sda_f = line_f[1];
   wire scl_rise = scl_f && !scl_p_q;
   wire scl_fall = !scl_f && scl_p_q;
   wire start_det = scl_f && scl_p_q && sda_p_q && !sda_f;
   wire stop_det = scl_f && scl_p_q && !sda_p_q && sda_f;

   state_e state_q, state_d;
   logic [7:0] shift_q;
   logic [3:0] bit_cnt_q;
   wire byte_done = (bit_cnt_q == `I2CF_BYTE_BITS) && scl_fall;
   wire match = (shift_q[7:1] == own_addr);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_ADDR: begin
            if (byte_done) begin
               state_d = match ? ST_ADDR_ACK : ST_IGNORE;
            end
         end
         ST_ADDR_ACK: begin
            if (scl_fall) begin
               state_d = read_q ? ST_BUSY : ST_CMD;
            end
         end
         ST_CMD: begin
            if (byte_done) begin
               state_d = ST_CMD_ACK;
            end
         end
         ST_CMD_ACK: begin
            if (scl_fall) begin
               state_d = ST_BUSY;
            end
         end
         ST_STANDBY, ST_BUSY, ST_IGNORE: state_d = state_q;
         default: state_d = ST_STANDBY;
      endcase
      // start wins over stop; either overrides the byte sequence
      if (stop_det) begin
         state_d = ST_STANDBY;
      end
      if (start_det) begin
         state_d = ST_ADDR;
      end
   end

   wire ack_drive_d = (state_d == ST_ADDR_ACK) || (state_d == ST_CMD_ACK);
   wire rx_state = (state_q == ST_ADDR) || (state_q == ST_CMD);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q <= ST_STANDBY;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         shift_q <= 8'h00;
         bit_cnt_q <= 4'h0;
         sda_out_q <= 1'b0;
         sda_oe_q <= 1'b0;
         standby_q <= 1'b1;
         addr_match_q <= 1'b0;
         read_q <= 1'b0;
         cmd_valid_q <= 1'b0;
         cmd_q <= `I2CF_CMD_RESET;
         port_level_q <= PORT_WIDTH'(`I2CF_PORT_RESET);
      end else if (ce) begin
         scl_p_q <= scl_f;
         sda_p_q <= sda_f;
         state_q <= state_d;
         sda_oe_q <= ack_drive_d;
         standby_q <= (state_d == ST_STANDBY);
         cmd_valid_q <= 1'b0;
         if (start_det || (state_q != state_d)) begin
            bit_cnt_q <= 4'h0;
         end else if (rx_state && scl_rise && bit_cnt_q != `I2CF_BYTE_BITS) begin
            shift_q <= {shift_q[6:0], sda_f};
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
         if (start_det) begin
            addr_match_q <= 1'b0;
         end else if (state_q == ST_ADDR && byte_done) begin
            addr_match_q <= match;
            read_q <= (shift_q[`I2CF_DIR_BIT] == `I2CF_DIR_READ);
         end
         if (state_q == ST_CMD && byte_done) begin
            cmd_q <= shift_q;
            cmd_valid_q <= 1'b1;
         end
      end
   end

   standby_after_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ce && stop_det && !start_det |=> standby_q && state_q == ST_STANDBY)
      else $error("no standby after stop");

   ports_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(rst_n) |-> port_level_q == `I2CF_PORT_RESET && state_q == ST_STANDBY && !sda_oe_q)
      else $error("ports or bus logic not initialised");

   start_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ce && start_det |=> state_q == ST_ADDR && bit_cnt_q == 4'h0 && !sda_oe_q)
      else $error("start did not open address phase");

   match_ack_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(sda_oe_q) && state_q == ST_ADDR_ACK |-> shift_q[7:1] == own_addr && addr_match_q)
      else $error("address acknowledged without match");

   direction_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_q == ST_ADDR_ACK |-> read_q == shift_q[`I2CF_DIR_BIT])
      else $error("direction flag differs from address lsb");

   command_byte_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cmd_valid_q |-> $past(state_q) == ST_CMD && !read_q && cmd_q == shift_q ##1 !cmd_valid_q)
      else $error("command byte taken outside a write");

   ignore_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_q == ST_IGNORE |-> !sda_oe_q && !addr_match_q)
      else $error("data line driven on address mismatch");

   ack_one_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ce && sda_oe_q && !scl_fall && !start_det && !stop_det |=> sda_oe_q)
      else $error("acknowledge released before clock fell");

   ack_low_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(sda_oe_q) |-> !scl_f && !scl_p_q)
      else $error("acknowledge started outside clock low");
endmodule

// ==== i2c_master_model.sv ====
/*
 Bus master model: start, stop, byte transfer with ack sampling, spikes.
 Assumes a pulled-up data wire resolved by the bench; scl is driven only here.
*/
`timescale 1ns/1ps
module i2c_master_model (
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic start_c();
      sda_low = 1'b1;
      #400 scl = 1'b0;
   endtask
   task automatic stop_c();
      sda_low = 1'b1;
      #400 scl = 1'b1;
      #400 sda_low = 1'b0;
      #800;
   endtask
   // long low phase around ack: slave drive lags the pin by ~5 clocks
   task automatic xfer(input logic [7:0] b, output logic ack);
      int lo;
      for (int i = 0; i < 9; i++) begin
         lo = (i == 0 || i == 8) ? 900 : 400;
         #(lo - 200) sda_low = (i < 8) ? ~b[7 - i] : 1'b0;
         #200 scl = 1'b1;
         #390 ack = ~sda;
         #10 scl = 1'b0;
      end
   endtask
   // 50 ns pulse straddling one clock edge
   task automatic spike(input logic on_scl);
      #20;
      scl = scl ^ on_scl;
      sda_low = sda_low ^ !on_scl;
      #50;
      scl = scl ^ on_scl;
      sda_low = sda_low ^ !on_scl;
      #330;
   endtask
endmodule

// ==== i2c_slave_address_front_end_tb.sv ====
/*
 Self-checking bench of the serial slave address front end.
 Assumes i2c_master_model as the far side and the front end package.
*/
`timescale 1ns/1ps
module i2c_slave_address_front_end_tb;
   import i2c_front_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   strap_t addr_strap_bit0 = '0;
   strap_t addr_strap_bit1 = '0;
   strap_t addr_strap_bit2 = '0;
   logic scl, sda_low, sda_out_q, sda_oe_q, standby_q, addr_match_q, read_q, cmd_valid_q;
   logic [7:0] cmd_q;
   logic [15:0] port_level_q;
   wire logic sda;
   int error_cnt = 0;
   int checked = 0;
   int oe_cnt = 0;
   logic [7:0] exp_q[$];
   assign sda = !(sda_low || (sda_oe_q && !sda_out_q));
   i2c_master_model master_u (.scl, .sda_low, .sda);
   i2c_slave_address_front_end dut_u (.sys_clk, .rst_n, .ce, .scl_in(scl), .sda_in(sda), .sda_out_q, .sda_oe_q,
      .addr_strap_bit0, .addr_strap_bit1, .addr_strap_bit2, .standby_q, .addr_match_q, .read_q, .cmd_valid_q,
      .cmd_q, .port_level_q);
   initial forever #50 sys_clk = ~sys_clk;
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("checked %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   function automatic addr7_t model_addr(strap_t a2, strap_t a1, strap_t a0);
      case ({a2[1], a1[1]})
         2'b00: return {3'b010, a0[1], a2[0], a1[0], a0[0]};
         2'b01: return {3'b001, a0[1], a2[0], a1[0], a0[0]};
         2'b11: return {3'b101, a0[1], a2[0], a1[0], a0[0]};
         default: return {2'b11, a0[1], 1'b0, a2[0], a1[0], a0[0]};
      endcase
   endfunction
   always @(posedge sys_clk) begin
      if (sda_oe_q === 1'b1) oe_cnt++;
      if (cmd_valid_q === 1'b1) chk("cmd", exp_q.size() > 0 ? exp_q.pop_front() : 16'h01ff, cmd_q);
   end
   task automatic frame(input addr7_t a, input logic rd, input logic hit);
      logic ack;
      logic [7:0] c;
      c = 8'($urandom) & 8'h7f;
      oe_cnt = 0;
      master_u.start_c();
      master_u.xfer({a, rd}, ack);
      chk("ack", hit, ack);
      chk("match", hit, addr_match_q);
      chk("standby", 1'b0, standby_q);
      if (hit) chk("dir", rd, read_q);
      if (hit && !rd) begin
         exp_q.push_back(c);
         master_u.xfer(c, ack);
         chk("cmd ack", 1'b1, ack);
      end
      master_u.stop_c();
      chk("standby", 1'b1, standby_q);
      chk("pending", 16'h0000, 16'(exp_q.size()));
      if (!hit) chk("no drive", 16'h0000, 16'(oe_cnt));
   endtask
   initial begin
      repeat (90000) @(posedge sys_clk);
      error_cnt++;
      stop_test();
   end
   initial begin
      addr7_t a;
      logic ack;
      void'($urandom(32'h4974_3dff));
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(negedge sys_clk);
      chk("port", 16'hffff, port_level_q);
      chk("standby", 1'b1, standby_q);
      for (int n = 0; n < 12; n++) begin
         @(posedge sys_clk);
         addr_strap_bit0 <= (n == 0) ? 2'h3 : 2'($urandom);
         addr_strap_bit1 <= (n == 0) ? 2'h0 : 2'($urandom);
         addr_strap_bit2 <= (n == 0) ? 2'h2 : 2'($urandom);
         repeat (4) @(negedge sys_clk);
         a = model_addr(addr_strap_bit2, addr_strap_bit1, addr_strap_bit0);
         if (n == 0) chk("map", 16'h0071, 16'(a));
         frame(a, 1'b0, 1'b1);
         frame(a, 1'b1, 1'b1);
         frame(a ^ 7'(1 + $urandom % 127), 1'(n), 1'b0);
      end
      master_u.start_c();
      master_u.spike(1'b1);
      master_u.xfer({a, 1'b1}, ack);
      chk("spike ack", 1'b1, ack);
      master_u.stop_c();
      master_u.spike(1'b0);
      repeat (4) @(negedge sys_clk);
      chk("spike match", 1'b1, addr_match_q);
      @(posedge sys_clk);
      ce <= 1'b0;
      @(negedge sys_clk);
      master_u.start_c();
      master_u.stop_c();
      chk("frozen", 1'b1, addr_match_q);
      @(posedge sys_clk);
      ce <= 1'b1;
      repeat (4) @(negedge sys_clk);
      chk("frozen", 1'b1, standby_q);
      master_u.start_c();
      repeat (4) @(negedge sys_clk);
      chk("standby", 1'b0, standby_q);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      master_u.stop_c();
      chk("port", 16'hffff, port_level_q);
      chk("reset", 4'b1000, {standby_q, addr_match_q, sda_oe_q, cmd_valid_q});
      @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(negedge sys_clk);
      frame(a, 1'b0, 1'b1);
      stop_test();
   end
endmodule
